/* File: card_pins_pkg.sv */
// Shared constants, modes and timing for the card host-pin link
// Contract
// - Host drives mode select low for IDE
// - Memory mode: ready low busy, high ready
// - Ready stays low until initialization completes
// - Host makes no access while ready low
// - Ready high if reset held since power-up
// - I/O mode interrupt: low pulse or level
// - IDE mode interrupt request is active high
// - Space select high common, low attribute
// - Space select low during I/O cycles
// - Host asserts DMA acknowledge answering DMA request
// - DMA disabled: device ignores DMA acknowledge
// - Host without DMA holds acknowledge high
// - PC Card modes: reset active high
// - IDE mode: reset active low
// - PC Card modes: wait never asserted
// - IDE outside Ultra DMA: pin is IORDY
// - Device ready-to-receive may pause write burst
// - Device strobes out; host latches both edges
// - Device pauses data-out by stopping strobe edges
// - First voltage sense grounded, second reserved
// - Acknowledged transfers are 16 bits wide
// - Host stop ends the Ultra DMA burst
package card_pins_pkg;
    localparam int unsigned CLK_MHZ            = 200;
    localparam int unsigned DATA_W             = 16;
    localparam int unsigned INIT_NS            = 1000;
    localparam int unsigned INIT_CYCLES        = (INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned INIT_W             = 8;
    localparam int unsigned IRQ_PULSE_NS       = 100;
    localparam int unsigned IRQ_PULSE_CYCLES   = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned IRQ_W              = 5;
    localparam int unsigned STROBE_HALF_NS     = 30;
    localparam int unsigned STROBE_HALF_CYCLES = (STROBE_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned STROBE_MID         = STROBE_HALF_CYCLES / 2;
    localparam int unsigned PH_W               = 3;
    localparam int unsigned SETTLE_CYCLES      = 3;
    localparam int unsigned SETTLE_W           = 2;

    typedef enum logic [1:0] {
        MODE_MEM = 2'b00,
        MODE_IO  = 2'b01,
        MODE_IDE = 2'b10
    } card_mode_e;

    typedef enum logic [1:0] {
        BURST_IDLE = 2'b00,
        BURST_OUT  = 2'b01,
        BURST_IN   = 2'b10
    } burst_e;
endpackage

/* File: card_link_if.sv */
// Pin-level link between card and host, with shared-pin resolution
`timescale 1ns/100ps
interface card_link_if;
    import card_pins_pkg::*;
    logic              ide_mode_select_n;
    logic              card_reset;
    logic              space_select;
    logic              ready_irq;
    logic              wait_strobe;
    logic              dmarq;
    logic              dmack_n;
    logic              stop;
    logic              host_strobe;
    logic [DATA_W-1:0] host_data;
    logic              host_data_oe;
    logic [DATA_W-1:0] dev_data;
    logic              dev_data_oe;
    logic [DATA_W-1:0] data;
    logic              voltage_sense_low_out;
    logic              voltage_sense_low_oe;
    logic              voltage_sense_low_n;
    logic              voltage_sense_secondary_oe;
    logic              voltage_sense_secondary_n;

    // Undriven lines float high through the socket pull-ups
    assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : '1);
    assign voltage_sense_low_n = voltage_sense_low_oe ? voltage_sense_low_out : 1'b1;
    assign voltage_sense_secondary_n = ~voltage_sense_secondary_oe;

    modport device (
        input  ide_mode_select_n, card_reset, space_select, dmack_n, stop, host_strobe, data,
        output ready_irq, wait_strobe, dmarq, dev_data, dev_data_oe,
        output voltage_sense_low_out, voltage_sense_low_oe, voltage_sense_secondary_oe
    );
    modport host (
        input  ready_irq, wait_strobe, dmarq, data, voltage_sense_low_n, voltage_sense_secondary_n,
        output ide_mode_select_n, card_reset, space_select, dmack_n, stop, host_strobe,
        output host_data, host_data_oe
    );
endinterface

/* File: card_device_end.sv */
// Card end: reset, ready/interrupt, DMA and Ultra DMA pin behaviour
`timescale 1ns/100ps
module card_device_end
    import card_pins_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    card_link_if.device            link,
    input  wire logic              io_mode,
    input  wire logic              busy,
    input  wire logic              irq_req,
    input  wire logic              irq_level_mode,
    input  wire logic              pio_wait,
    input  wire logic              dma_enable,
    input  wire logic              dma_req,
    input  wire logic              udma_enable,
    input  wire logic              udma_dir_out,
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output logic                   tx_taken,
    input  wire logic              rx_ready,
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_valid,
    output logic                   dma_ack,
    output logic                   attribute_access,
    output logic                   card_busy,
    output card_mode_e             mode
);
    typedef struct packed {
        logic                rst_s1;
        logic                rst_s2;
        logic                sel_s1;
        logic                sel_s2;
        logic                spc_s1;
        logic                spc_s2;
        logic                ack_s1;
        logic                ack_s2;
        logic                stp_s1;
        logic                stp_s2;
        logic                hst_s1;
        logic                hst_s2;
        logic                hst_d;
        logic [DATA_W-1:0]   dat_s1;
        logic [DATA_W-1:0]   dat_s2;
        logic                fresh;
        logic                held;
        logic [SETTLE_W-1:0] settle;
        logic                initing;
        logic [INIT_W-1:0]   init_cnt;
        logic                irq_d;
        logic [IRQ_W-1:0]    irq_cnt;
        burst_e              burst;
        logic [PH_W-1:0]     phase;
        logic                dstb;
        logic [DATA_W-1:0]   dout;
        logic                doe;
        logic [DATA_W-1:0]   rx_data;
        logic                rx_valid;
        logic                tx_take;
        logic                ready_pin;
        logic                wait_pin;
        logic                dmarq;
        logic                ack;
        logic                attr;
    } dev_state_s;

    localparam dev_state_s DEV_RESET = '{
        fresh:    1'b1,
        initing:  1'b1,
        init_cnt: INIT_W'(INIT_CYCLES),
        settle:   SETTLE_W'(SETTLE_CYCLES),
        wait_pin: 1'b1,
        sel_s1:   1'b1,
        sel_s2:   1'b1,
        ack_s1:   1'b1,
        ack_s2:   1'b1,
        burst:    BURST_IDLE,
        default:  '0
    };

    dev_state_s s;
    dev_state_s next_s;
    card_mode_e cur_mode;
    logic       eff_rst;
    logic       in_reset;
    logic       dma_on;

    always_comb begin
        next_s = s;
        next_s.rst_s1 = link.card_reset;
        next_s.rst_s2 = s.rst_s1;
        next_s.sel_s1 = link.ide_mode_select_n;
        next_s.sel_s2 = s.sel_s1;
        next_s.spc_s1 = link.space_select;
        next_s.spc_s2 = s.spc_s1;
        next_s.ack_s1 = link.dmack_n;
        next_s.ack_s2 = s.ack_s1;
        next_s.stp_s1 = link.stop;
        next_s.stp_s2 = s.stp_s1;
        next_s.hst_s1 = link.host_strobe;
        next_s.hst_s2 = s.hst_s1;
        next_s.hst_d  = s.hst_s2;
        next_s.dat_s1 = link.data;
        next_s.dat_s2 = s.dat_s1;
        next_s.irq_d  = irq_req;
        next_s.tx_take  = 1'b0;
        next_s.rx_valid = 1'b0;

        cur_mode = ~s.sel_s2 ? MODE_IDE : (io_mode ? MODE_IO : MODE_MEM);
        eff_rst  = (cur_mode == MODE_IDE) ? ~s.rst_s2 : s.rst_s2;

        // Power-up: let synchronisers settle before judging the reset pin
        if (s.settle != '0) begin
            next_s.settle = s.settle - SETTLE_W'(1);
        end else if (eff_rst) begin
            next_s.initing  = 1'b1;
            next_s.init_cnt = INIT_W'(INIT_CYCLES);
            next_s.held     = s.fresh ? 1'b1 : s.held;
        end else if (s.fresh) begin
            next_s.fresh   = 1'b0;
            next_s.initing = s.held;
        end else if (s.initing) begin
            next_s.init_cnt = s.init_cnt - INIT_W'(1);
            if (s.init_cnt == INIT_W'(1)) begin
                next_s.initing = 1'b0;
            end
        end
        in_reset = eff_rst | s.initing | (s.settle != '0);

        if (in_reset) begin
            next_s.irq_cnt = '0;
        end else if (irq_req & ~s.irq_d & ~irq_level_mode) begin
            next_s.irq_cnt = IRQ_W'(IRQ_PULSE_CYCLES);
        end else if (s.irq_cnt != '0) begin
            next_s.irq_cnt = s.irq_cnt - IRQ_W'(1);
        end

        case (cur_mode)
            MODE_MEM: begin
                if (s.fresh & eff_rst & (s.settle == '0)) begin
                    next_s.ready_pin = 1'b1;
                end else begin
                    next_s.ready_pin = ~in_reset & ~busy;
                end
            end
            MODE_IO: begin
                if (in_reset) begin
                    next_s.ready_pin = 1'b1;
                end else if (irq_level_mode) begin
                    next_s.ready_pin = ~irq_req;
                end else begin
                    next_s.ready_pin = (s.irq_cnt == '0);
                end
            end
            MODE_IDE: next_s.ready_pin = ~in_reset & irq_req;
            default:  next_s.ready_pin = 1'b0;
        endcase

        // Acknowledge only counts while DMA is enabled
        dma_on = (cur_mode == MODE_IDE) & dma_enable & ~s.ack_s2 & ~in_reset;
        next_s.ack   = dma_on;
        next_s.dmarq = (cur_mode == MODE_IDE) & dma_enable & dma_req & ~in_reset;
        next_s.attr  = (cur_mode == MODE_MEM) & ~s.spc_s2;

        case (s.burst)
            BURST_IDLE: begin
                next_s.doe   = 1'b0;
                next_s.phase = '0;
                if (dma_on & udma_enable & ~s.stp_s2) begin
                    next_s.burst = udma_dir_out ? BURST_OUT : BURST_IN;
                    // Strobe starts at the pin's level, so entry is no edge
                    next_s.dstb  = s.wait_pin;
                end
            end
            BURST_OUT: begin
                if (~dma_on | s.stp_s2) begin
                    next_s.burst = BURST_IDLE;
                    next_s.doe   = 1'b0;
                end else begin
                    next_s.doe = 1'b1;
                    // No data means no strobe edges, which pauses the host
                    if ((s.phase != '0) | tx_valid) begin
                        if (s.phase == '0) begin
                            next_s.dout    = tx_data;
                            next_s.tx_take = 1'b1;
                        end
                        if (s.phase == PH_W'(STROBE_MID)) begin
                            next_s.dstb = ~s.dstb;
                        end
                        if (s.phase == PH_W'(STROBE_HALF_CYCLES - 1)) begin
                            next_s.phase = '0;
                        end else begin
                            next_s.phase = s.phase + PH_W'(1);
                        end
                    end
                end
            end
            BURST_IN: begin
                if (~dma_on | s.stp_s2) begin
                    next_s.burst = BURST_IDLE;
                end else if (s.hst_s2 != s.hst_d) begin
                    next_s.rx_data  = s.dat_s2;
                    next_s.rx_valid = 1'b1;
                end
            end
            default: next_s.burst = BURST_IDLE;
        endcase

        case (next_s.burst)
            BURST_OUT: next_s.wait_pin = next_s.dstb;
            BURST_IN:  next_s.wait_pin = ~rx_ready;
            default:   next_s.wait_pin = (cur_mode == MODE_IDE) ? ~pio_wait : 1'b1;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= DEV_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign link.ready_irq   = s.ready_pin;
    assign link.wait_strobe = s.wait_pin;
    assign link.dmarq       = s.dmarq;
    assign link.dev_data    = s.dout;
    assign link.dev_data_oe = s.doe;
    // Grounded first sense line, second left undriven as reserved
    assign link.voltage_sense_low_out      = 1'b0;
    assign link.voltage_sense_low_oe       = 1'b1;
    assign link.voltage_sense_secondary_oe = 1'b0;

    assign tx_taken         = s.tx_take;
    assign rx_data          = s.rx_data;
    assign rx_valid         = s.rx_valid;
    assign dma_ack          = s.ack;
    assign attribute_access = s.attr;
    assign card_busy        = ~s.fresh & (s.initing | s.rst_s2 ^ (s.sel_s2 == 1'b0));
    assign mode             = ~s.sel_s2 ? MODE_IDE : (io_mode ? MODE_IO : MODE_MEM);
endmodule

/* File: card_host_end.sv */
// Host end: mode, reset, space select, DMA acknowledge and Ultra DMA data
`timescale 1ns/100ps
module card_host_end
    import card_pins_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    card_link_if.host              link,
    input  wire logic              ide_mode,
    input  wire logic              io_mode,
    input  wire logic              attr_space,
    input  wire logic              reset_req,
    input  wire logic              dma_enable,
    input  wire logic              udma_enable,
    input  wire logic              udma_in,
    input  wire logic              stop_req,
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output logic                   tx_taken,
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_valid,
    output logic                   card_ready,
    output logic                   card_irq
);
    typedef struct packed {
        logic              rdy_s1;
        logic              rdy_s2;
        logic              ws_s1;
        logic              ws_s2;
        logic              ws_d;
        logic              rq_s1;
        logic              rq_s2;
        logic [DATA_W-1:0] dat_s1;
        logic [DATA_W-1:0] dat_s2;
        logic              ide_sel_n;
        logic              reset_pin;
        logic              space;
        logic              dmack_n;
        logic              stop;
        logic [PH_W-1:0]   phase;
        logic              hstb;
        logic [DATA_W-1:0] hdout;
        logic              hdoe;
        logic              tx_take;
        logic [DATA_W-1:0] rx_data;
        logic              rx_valid;
        logic              ready;
        logic              irq;
    } host_state_s;

    localparam host_state_s HOST_RESET = '{
        ide_sel_n: 1'b1,
        reset_pin: 1'b1,
        space:     1'b1,
        dmack_n:   1'b1,
        default:   '0
    };

    host_state_s s;
    host_state_s next_s;
    logic        xfer;

    always_comb begin
        next_s = s;
        next_s.rdy_s1 = link.ready_irq;
        next_s.rdy_s2 = s.rdy_s1;
        next_s.ws_s1  = link.wait_strobe;
        next_s.ws_s2  = s.ws_s1;
        next_s.ws_d   = s.ws_s2;
        next_s.rq_s1  = link.dmarq;
        next_s.rq_s2  = s.rq_s1;
        next_s.dat_s1 = link.data;
        next_s.dat_s2 = s.dat_s1;
        next_s.tx_take  = 1'b0;
        next_s.rx_valid = 1'b0;

        next_s.ide_sel_n = ~ide_mode;
        next_s.reset_pin = ide_mode ? ~reset_req : reset_req;
        if (ide_mode) begin
            next_s.space = 1'b1;
        end else if (io_mode) begin
            next_s.space = 1'b0;
        end else begin
            next_s.space = ~attr_space;
        end
        // Without DMA the acknowledge stays high
        next_s.dmack_n = ~(ide_mode & dma_enable & s.rq_s2);
        next_s.stop    = stop_req;

        // Memory-mode access is only offered once ready is seen high; I/O and IDE modes always report ready
        next_s.ready = (ide_mode | io_mode) ? 1'b1 : s.rdy_s2;
        next_s.irq   = ide_mode ? s.rdy_s2 : (io_mode & ~s.rdy_s2);

        xfer = ~s.dmack_n & udma_enable & ~s.stop;
        if (xfer & udma_in) begin
            next_s.hdoe = 1'b1;
            // Device ready-to-receive gates each new word
            if ((s.phase != '0) | (tx_valid & ~s.ws_s2)) begin
                if (s.phase == '0) begin
                    next_s.hdout   = tx_data;
                    next_s.tx_take = 1'b1;
                end
                if (s.phase == PH_W'(STROBE_MID)) begin
                    next_s.hstb = ~s.hstb;
                end
                if (s.phase == PH_W'(STROBE_HALF_CYCLES - 1)) begin
                    next_s.phase = '0;
                end else begin
                    next_s.phase = s.phase + PH_W'(1);
                end
            end
        end else begin
            next_s.hdoe  = 1'b0;
            next_s.phase = '0;
        end

        if (xfer & ~udma_in & (s.ws_s2 != s.ws_d)) begin
            next_s.rx_data  = s.dat_s2;
            next_s.rx_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= HOST_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign link.ide_mode_select_n = s.ide_sel_n;
    assign link.card_reset        = s.reset_pin;
    assign link.space_select      = s.space;
    assign link.dmack_n           = s.dmack_n;
    assign link.stop              = s.stop;
    assign link.host_strobe       = s.hstb;
    assign link.host_data         = s.hdout;
    assign link.host_data_oe      = s.hdoe;

    assign tx_taken   = s.tx_take;
    assign rx_data    = s.rx_data;
    assign rx_valid   = s.rx_valid;
    assign card_ready = s.ready;
    assign card_irq   = s.irq;
endmodule

/* File: card_host_pin_control_sva.sv */
// Concurrent checks on the card link pins
`timescale 1ns/100ps
module card_host_pin_control_sva
    import card_pins_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              ide_mode_select_n,
    input wire logic              card_reset,
    input wire logic              ready_irq,
    input wire logic              wait_strobe,
    input wire logic              dmarq,
    input wire logic              dmack_n,
    input wire logic              stop,
    input wire logic [DATA_W-1:0] dev_data,
    input wire logic              dev_data_oe,
    input wire logic              voltage_sense_low_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Only PC-mode releases; the bench never resets in I/O mode
    sequence reset_released;
        $fell(card_reset) && ide_mode_select_n;
    endsequence
    sequence init_low;
        ##[1:8] !ready_irq ##1 (!ready_irq) [*8];
    endsequence
    sequence strobe_edge;
        $past(dev_data_oe) && dev_data_oe && $changed(wait_strobe);
    endsequence

    chk_sense_grounded: assert property (!$past(rst) |-> !voltage_sense_low_n)
        else $error("sense low pin not grounded");
    chk_no_pc_wait: assert property (ide_mode_select_n [*8] |-> wait_strobe)
        else $error("wait asserted in PC mode");
    chk_init_ready_low: assert property (reset_released |-> init_low)
        else $error("ready not low during init");
    chk_init_ready_end: assert property (reset_released |-> ##[150:300] ready_irq)
        else $error("ready never returned after init");
    chk_ack_after_req: assert property ($fell(dmack_n) |-> $past(dmarq, 2))
        else $error("acknowledge without request");
    chk_no_ack_quiet: assert property (dmack_n [*8] |-> !dev_data_oe)
        else $error("data driven without acknowledge");
    // Host latches on the edge, so data must not move around it
    chk_strobe_data_held: assert property (strobe_edge |-> $stable(dev_data) ##1 $stable(dev_data))
        else $error("data moved at strobe edge");
    chk_strobe_spacing: assert property (strobe_edge |=> (!$changed(wait_strobe)) [*5])
        else $error("strobe edges too close");
    chk_stop_ends_burst: assert property (stop && !dmack_n |-> ##[1:10] !dev_data_oe)
        else $error("burst not ended by stop");
endmodule

/* File: card_host_pin_control_tb.sv */
// Self-checking bench: card and host ends joined by the pin link
`timescale 1ns/100ps
module card_host_pin_control_tb
    import card_pins_pkg::*;
;
    logic              clk;
    logic              rst;
    logic              io_mode, busy, irq_req, irq_level_mode, pio_wait, dev_dma_en, host_dma_en, dma_req;
    logic              udma_enable, udma_dir_out, rx_ready, dev_tx_valid, ide_mode, attr_space, reset_req;
    logic              stop_req, host_tx_valid, dev_tx_taken, dev_rx_valid, dma_ack, attribute_access;
    logic              card_busy, host_tx_taken, host_rx_valid, card_ready, card_irq;
    logic [DATA_W-1:0] dev_tx_data, dev_rx_data, host_tx_data, host_rx_data;
    card_mode_e        mode;
    int                n_errors = 0;
    int                num_checks = 0;
    int                cycles = 0;

    card_link_if card_link_if_inst ();
    card_device_end card_device_end_inst (
        .clk(clk), .rst(rst), .link(card_link_if_inst), .io_mode(io_mode), .busy(busy), .irq_req(irq_req),
        .irq_level_mode(irq_level_mode), .pio_wait(pio_wait), .dma_enable(dev_dma_en), .dma_req(dma_req),
        .udma_enable(udma_enable), .udma_dir_out(udma_dir_out), .tx_data(dev_tx_data), .tx_valid(dev_tx_valid),
        .tx_taken(dev_tx_taken), .rx_ready(rx_ready), .rx_data(dev_rx_data), .rx_valid(dev_rx_valid),
        .dma_ack(dma_ack), .attribute_access(attribute_access), .card_busy(card_busy), .mode(mode));
    card_host_end card_host_end_inst (
        .clk(clk), .rst(rst), .link(card_link_if_inst), .ide_mode(ide_mode), .io_mode(io_mode),
        .attr_space(attr_space), .reset_req(reset_req), .dma_enable(host_dma_en), .udma_enable(udma_enable),
        .udma_in(!udma_dir_out), .stop_req(stop_req), .tx_data(host_tx_data), .tx_valid(host_tx_valid),
        .tx_taken(host_tx_taken), .rx_data(host_rx_data), .rx_valid(host_rx_valid), .card_ready(card_ready),
        .card_irq(card_irq));
    card_host_pin_control_sva sva_inst (
        .clk(clk), .rst(rst), .ide_mode_select_n(card_link_if_inst.ide_mode_select_n),
        .card_reset(card_link_if_inst.card_reset), .ready_irq(card_link_if_inst.ready_irq),
        .wait_strobe(card_link_if_inst.wait_strobe), .dmarq(card_link_if_inst.dmarq),
        .dmack_n(card_link_if_inst.dmack_n), .stop(card_link_if_inst.stop), .dev_data(card_link_if_inst.dev_data),
        .dev_data_oe(card_link_if_inst.dev_data_oe), .voltage_sense_low_n(card_link_if_inst.voltage_sense_low_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Run is about 1700 cycles; a stuck handshake lands here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Extra settle covers the host's pin synchronisers
    task automatic wait_idle;
        cyc(10);
        for (int i = 0; i < 400 && card_busy !== 1'b0; i++) @(posedge clk);
        cyc(6);
    endtask

    task automatic t_power;
        cyc(10);
        chk("ready held", 1'b1, card_link_if_inst.ready_irq);
        chk("busy while held", 1'b0, card_busy);
        reset_req <= 1'b0;
        cyc(20);
        chk("ready in init", 1'b0, card_ready);
        wait_idle();
        chk("ready after init", 1'b1, card_ready);
        chk("mode", MODE_MEM, mode);
        chk("sense low", 1'b0, card_link_if_inst.voltage_sense_low_n);
        chk("sense second", 1'b1, card_link_if_inst.voltage_sense_secondary_n);
    endtask

    task automatic t_mem;
        pio_wait <= 1'b1;
        busy <= 1'b1;
        cyc(10);
        chk("ready busy", 1'b0, card_ready);
        chk("wait pin", 1'b1, card_link_if_inst.wait_strobe);
        busy <= 1'b0;
        attr_space <= 1'b1;
        cyc(10);
        chk("ready idle", 1'b1, card_ready);
        chk("space pin", 1'b0, card_link_if_inst.space_select);
        chk("attribute", 1'b1, attribute_access);
        attr_space <= 1'b0;
        pio_wait <= 1'b0;
        cyc(10);
        chk("common", 1'b0, attribute_access);
    endtask

    task automatic t_io;
        int n;
        io_mode <= 1'b1;
        irq_level_mode <= 1'b1;
        irq_req <= 1'b1;
        cyc(10);
        chk("mode", MODE_IO, mode);
        chk("space in io", 1'b0, card_link_if_inst.space_select);
        chk("level irq", 1'b0, card_link_if_inst.ready_irq);
        chk("host irq", 1'b1, card_irq);
        irq_req <= 1'b0;
        irq_level_mode <= 1'b0;
        cyc(10);
        chk("irq idle", 1'b1, card_link_if_inst.ready_irq);
        irq_req <= 1'b1;
        n = 0;
        repeat (60) begin
            @(posedge clk);
            if (card_link_if_inst.ready_irq === 1'b0) n++;
        end
        chk("pulse length", 16'(IRQ_PULSE_CYCLES), 16'(n));
        irq_req <= 1'b0;
    endtask

    task automatic t_ide;
        ide_mode <= 1'b1;
        io_mode <= 1'b0;
        wait_idle();
        chk("mode", MODE_IDE, mode);
        chk("mode pin", 1'b0, card_link_if_inst.ide_mode_select_n);
        pio_wait <= 1'b1;
        irq_req <= 1'b1;
        cyc(10);
        chk("iordy", 1'b0, card_link_if_inst.wait_strobe);
        chk("intrq", 1'b1, card_link_if_inst.ready_irq);
        chk("host irq", 1'b1, card_irq);
        pio_wait <= 1'b0;
        irq_req <= 1'b0;
        reset_req <= 1'b1;
        cyc(10);
        chk("reset pin", 1'b0, card_link_if_inst.card_reset);
        chk("busy in reset", 1'b1, card_busy);
        reset_req <= 1'b0;
        wait_idle();
    endtask

    task automatic t_dma;
        dma_req <= 1'b1;
        cyc(20);
        chk("ack without dma", 1'b1, card_link_if_inst.dmack_n);
        host_dma_en <= 1'b1;
        cyc(12);
        chk("ack pin", 1'b0, card_link_if_inst.dmack_n);
        chk("dma_ack", 1'b1, dma_ack);
        dev_dma_en <= 1'b0;
        cyc(10);
        chk("ack ignored", 1'b0, dma_ack);
        dma_req <= 1'b0;
        dev_dma_en <= 1'b1;
        cyc(20);
    endtask

    // Four words with a pause before the third; out is card to host
    task automatic t_burst(input logic out);
        int r;
        int w;
        r = 0;
        udma_dir_out <= out;
        udma_enable <= 1'b1;
        dma_req <= 1'b1;
        fork
            for (int k = 0; k < 4; k++) begin
                if (k == 2) begin
                    rx_ready <= 1'b0;
                    cyc(30);
                    if (!out) chk("ready to receive", 1'b1, card_link_if_inst.wait_strobe);
                    rx_ready <= 1'b1;
                end
                dev_tx_data <= 16'hc3a0 + k[15:0];
                host_tx_data <= 16'hc3a0 + k[15:0];
                dev_tx_valid <= out;
                host_tx_valid <= !out;
                w = 0;
                do begin
                    @(posedge clk);
                    w++;
                end while ((out ? dev_tx_taken : host_tx_taken) !== 1'b1 && w < 300);
                if (k[0]) dev_tx_valid <= 1'b0;
                if (k[0]) host_tx_valid <= 1'b0;
            end
            repeat (500) begin
                @(posedge clk);
                if ((out ? host_rx_valid : dev_rx_valid) === 1'b1) begin
                    chk("burst word", 16'hc3a0 + r[15:0], out ? host_rx_data : dev_rx_data);
                    r++;
                end
            end
        join
        chk("word count", 16'h4, r[15:0]);
        stop_req <= 1'b1;
        cyc(15);
        chk("data released", 1'b0, card_link_if_inst.dev_data_oe);
        stop_req <= 1'b0;
        dma_req <= 1'b0;
        udma_enable <= 1'b0;
        cyc(20);
    endtask

    initial begin
        rst = 1'b1;
        {io_mode, busy, irq_req, irq_level_mode, pio_wait, host_dma_en, dma_req, udma_enable} = 8'h0;
        {udma_dir_out, dev_tx_valid, ide_mode, attr_space, stop_req, host_tx_valid} = 6'h0;
        {dev_dma_en, rx_ready, reset_req} = 3'h7;
        dev_tx_data = 16'h0;
        host_tx_data = 16'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_power();
        t_mem();
        t_io();
        t_ide();
        t_dma();
        t_burst(1'b1);
        t_burst(1'b0);
        tally_and_finish();
    end
endmodule
